// >>> logic/srs_pkg.sv
// constants shared by the system reset sequencer
package srs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POWER_ON_DELAY_NS = 10000;
  localparam int unsigned BROWN_OUT_DELAY_NS = 10000;
  localparam int unsigned MASTER_CLEAR_PIN_MIN_PULSE_NS = 2000;
  localparam int unsigned CLOCK_MONITOR_START_DELAY_NS = 5000;
  localparam int unsigned OSCD_FRC_NS = 1100;
  localparam int unsigned OSCD_LOW_POWER_INTERNAL_RC_NS = 70000;
  localparam int unsigned PLL_LOCK_NS = 1500000;
  localparam int unsigned POWER_UP_TIMER_STEP_NS = 1000000;
  localparam int unsigned OST_PERIODS = 1024;
  // least times round up, longest times round down
  localparam int unsigned POWER_ON_DELAY_CYC = (POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BROWN_OUT_DELAY_CYC = (BROWN_OUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MASTER_CLEAR_PIN_MIN_CYC = (MASTER_CLEAR_PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLOCK_MONITOR_START_CYC =
    (CLOCK_MONITOR_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSCD_FRC_CYC = OSCD_FRC_NS / CLK_PERIOD_NS;
  localparam int unsigned OSCD_LOW_POWER_INTERNAL_RC_CYC = OSCD_LOW_POWER_INTERNAL_RC_NS / CLK_PERIOD_NS;
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_NS / CLK_PERIOD_NS;
  localparam int unsigned POWER_UP_TIMER_STEP_CYC = POWER_UP_TIMER_STEP_NS / CLK_PERIOD_NS;

  // ****************************************
  // oscillator modes
  // ****************************************
  localparam logic [2:0] OSC_FRC = 3'h0;
  localparam logic [2:0] OSC_FRCPLL = 3'h1;
  localparam logic [2:0] OSC_XT = 3'h2;
  localparam logic [2:0] OSC_XTPLL = 3'h3;
  localparam logic [2:0] OSC_EC = 3'h4;
  localparam logic [2:0] OSC_ECPLL = 3'h5;
  localparam logic [2:0] OSC_LOW_POWER_INTERNAL_RC = 3'h6;
  localparam logic [2:0] OSC_FRCDIV = 3'h7;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] RESET_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] OSC_CONTROL_REG_OFS = 8'h04;
  localparam logic [7:0] SEQ_CONFIG_REG_OFS = 8'h08;
  localparam logic [7:0] SEQ_STATUS_REG_OFS = 8'h0c;
  localparam int unsigned POR_BIT = 0;
  localparam int unsigned BOR_BIT = 1;
  localparam int unsigned WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int unsigned SWR_BIT = 6;
  localparam int unsigned EXTERNAL_RESET_FLAG_BIT = 7;
  localparam logic [15:0] RESET_CONTROL_REG_MASK = 16'h00d3;
  localparam logic [15:0] RESET_CONTROL_REG_RESET = 16'h0003;
  localparam int unsigned CUR_OSC_LSB = 12;
  localparam int unsigned CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT = 0;
  localparam int unsigned CFG_POWER_UP_TIMER_LSB = 1;
  localparam logic [3:0] CFG_RESET = 4'he;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    ST_POR = 4'h0,
    ST_BOR = 4'h1,
    ST_POWER_UP_TIMER = 4'h2,
    ST_OSCD = 4'h3,
    ST_OST = 4'h4,
    ST_LOCK = 4'h5,
    ST_RUN = 4'h6,
    ST_MASTER_CLEAR_PIN = 4'h7,
    ST_PULSE = 4'h8
  } srs_state_type;

endpackage

// >>> logic/srs_reset_seq.sv
// system reset sequencer with AHB-Lite register slave
// Behaviour
// - power-on or brown-out is cold; clock source comes from the select input.
// - all other resets are warm; the current clock field stays unchanged.
// - power-on holds reset until supply threshold seen plus power-on delay.
// - power-on reset sets flag bit 0 of the reset control register.
// - below brown-out threshold hold reset; release after threshold plus delay.
// - brown-out reset sets flag bit 1 of the reset control register.
// - power-up timer holds reset after brown-out; then oscillator starts.
// - power-up delay picked by 3-bit field, eight settings 0 to 128 ms.
// - brown-out plus power-up delay restarts whenever supply recovers.
// - clock-ready delay chain depends on oscillator mode.
// - start-up timer counts 1024 oscillator periods for crystal modes.
// - PLL modes wait about 1.5 ms lock time before execution.
// - start-up allowance at most 1.1 us fast RC, 70 us low-power RC.
// - once clock is ready the processor fetches from address zero.
// - clock monitor starts after clock ready plus its own start delay.
// - master clear pin is active low, glitch filtered, minimum width.
// - master clear reset sets the external reset flag.
// - software reset asserts reset, keeps clock, releases next cycle.
// - software reset sets flag bit 6.
// - watchdog time-out in run asserts reset, clock unchanged.
// - watchdog time-out in sleep or idle only wakes the processor.
// - watchdog reset sets flag bit 4.
// - power-on and brown-out drive the system reset active in any state, the other sources only from run.
// - power-on clears every status flag except the power-on and brown-out flags.
// - software may set or clear any flag without causing a reset.
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module srs_reset_seq #(
  parameter int unsigned OSCD_LOW_POWER_INTERNAL_RC_CYC = srs_pkg::OSCD_LOW_POWER_INTERNAL_RC_CYC,
  parameter int unsigned PLL_LOCK_CYC = srs_pkg::PLL_LOCK_CYC,
  parameter int unsigned POWER_UP_TIMER_STEP_CYC = srs_pkg::POWER_UP_TIMER_STEP_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // reset sources
  input wire logic supply_above_por,
  input wire logic supply_above_bor,
  input wire logic master_clear_pin_n,
  input wire logic sw_reset_req,
  input wire logic wdt_timeout,
  input wire logic cpu_sleep_or_idle,
  // oscillator
  input wire logic [2:0] initial_osc_select,
  input wire logic osc_tick,
  // system side
  output logic system_reset_n,
  output logic [2:0] clk_source_sel,
  output logic osc_enable,
  output logic clock_ready,
  output logic cpu_fetch_en,
  output logic [23:0] reset_vector,
  output logic clock_monitor_active,
  output logic wdt_wake
);

  // ****************************************
  // detector synchronisers
  // ****************************************
  logic [1:0] det_meta_q;
  logic [1:0] det_sync_q;
  logic por_ok;
  logic bor_ok;

  always_ff @(posedge ref_clk)
  begin
    // supplies treated as low under reset so the cold sequence always runs
    if (sys_rst)
    begin
      det_meta_q <= 2'h0;
      det_sync_q <= 2'h0;
    end
    else
    begin
      det_meta_q <= {supply_above_bor, supply_above_por};
      det_sync_q <= det_meta_q;
    end
  end

  assign por_ok = det_sync_q[0];
  assign bor_ok = det_sync_q[1];

  // ****************************************
  // master clear glitch filter
  // ****************************************
  logic [15:0] master_clear_pin_cnt_q;
  logic master_clear_pin_act;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || master_clear_pin_n)
      master_clear_pin_cnt_q <= 16'h0;
    else if (master_clear_pin_cnt_q != 16'(srs_pkg::MASTER_CLEAR_PIN_MIN_CYC))
      master_clear_pin_cnt_q <= master_clear_pin_cnt_q + 16'h1;
  end

  assign master_clear_pin_act = (master_clear_pin_cnt_q == 16'(srs_pkg::MASTER_CLEAR_PIN_MIN_CYC));

  // ****************************************
  // registers written by software
  // ****************************************
  logic pend_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [3:0] cfg_q;
  logic [2:0] clk_sel_q;
  logic we_reset_control_reg;
  logic we_cfg;

  assign we_reset_control_reg = pend_q && wr_q && (addr_q == srs_pkg::RESET_CONTROL_REG_OFS);
  assign we_cfg = pend_q && wr_q && (addr_q == srs_pkg::SEQ_CONFIG_REG_OFS);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cfg_q <= srs_pkg::CFG_RESET;
    else if (we_cfg)
      cfg_q <= hwdata[3:0];
  end

  // ****************************************
  // sequencer
  // ****************************************
  srs_pkg::srs_state_type state_q;
  logic [31:0] cnt_q;
  logic sw_evt;
  logic wdt_rst_evt;
  logic need_oscd;
  logic need_ost;
  logic need_lock;
  logic [31:0] oscd_load;
  logic [31:0] power_up_timer_load;

  assign sw_evt = sw_reset_req && (state_q == srs_pkg::ST_RUN);
  assign wdt_rst_evt = wdt_timeout && !cpu_sleep_or_idle && (state_q == srs_pkg::ST_RUN);
  // delay chain per oscillator mode
  assign need_oscd = (clk_sel_q != srs_pkg::OSC_EC) && (clk_sel_q != srs_pkg::OSC_ECPLL);
  assign need_ost = (clk_sel_q == srs_pkg::OSC_XT) || (clk_sel_q == srs_pkg::OSC_XTPLL);
  assign need_lock = (clk_sel_q == srs_pkg::OSC_FRCPLL) || (clk_sel_q == srs_pkg::OSC_XTPLL)
    || (clk_sel_q == srs_pkg::OSC_ECPLL);
  assign oscd_load = (clk_sel_q == srs_pkg::OSC_LOW_POWER_INTERNAL_RC) ? 32'(OSCD_LOW_POWER_INTERNAL_RC_CYC)
    : 32'(srs_pkg::OSCD_FRC_CYC);
  // setting 0 gives no delay, n gives 2^n steps, so 7 reaches 128 ms
  assign power_up_timer_load = (cfg_q[3:1] == 3'h0) ? 32'h0
    : (32'(POWER_UP_TIMER_STEP_CYC) << cfg_q[3:1]);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !por_ok)
    begin
      state_q <= srs_pkg::ST_POR;
      cnt_q <= 32'(srs_pkg::POWER_ON_DELAY_CYC);
    end
    else if (!bor_ok && state_q != srs_pkg::ST_POR)
    begin
      // reloading while low restarts the whole delay on each recovery
      state_q <= srs_pkg::ST_BOR;
      cnt_q <= 32'(srs_pkg::BROWN_OUT_DELAY_CYC);
    end
    else
    begin
      case (state_q)
        srs_pkg::ST_POR:
        begin
          if (cnt_q == 32'h0)
          begin
            state_q <= srs_pkg::ST_BOR;
            cnt_q <= 32'(srs_pkg::BROWN_OUT_DELAY_CYC);
          end
          else
            cnt_q <= cnt_q - 32'h1;
        end
        srs_pkg::ST_BOR:
        begin
          if (cnt_q == 32'h0)
          begin
            state_q <= srs_pkg::ST_POWER_UP_TIMER;
            cnt_q <= power_up_timer_load;
          end
          else
            cnt_q <= cnt_q - 32'h1;
        end
        srs_pkg::ST_POWER_UP_TIMER:
        begin
          if (cnt_q != 32'h0)
            cnt_q <= cnt_q - 32'h1;
          else if (need_oscd)
          begin
            state_q <= srs_pkg::ST_OSCD;
            cnt_q <= oscd_load;
          end
          else if (need_lock)
          begin
            state_q <= srs_pkg::ST_LOCK;
            cnt_q <= 32'(PLL_LOCK_CYC);
          end
          else
            state_q <= srs_pkg::ST_RUN;
        end
        srs_pkg::ST_OSCD:
        begin
          if (cnt_q != 32'h0)
            cnt_q <= cnt_q - 32'h1;
          else if (need_ost)
          begin
            state_q <= srs_pkg::ST_OST;
            cnt_q <= 32'(srs_pkg::OST_PERIODS);
          end
          else if (need_lock)
          begin
            state_q <= srs_pkg::ST_LOCK;
            cnt_q <= 32'(PLL_LOCK_CYC);
          end
          else
            state_q <= srs_pkg::ST_RUN;
        end
        srs_pkg::ST_OST:
        begin
          // counts oscillator periods, not system clocks
          if (cnt_q == 32'h0)
          begin
            state_q <= need_lock ? srs_pkg::ST_LOCK : srs_pkg::ST_RUN;
            cnt_q <= 32'(PLL_LOCK_CYC);
          end
          else if (osc_tick)
            cnt_q <= cnt_q - 32'h1;
        end
        srs_pkg::ST_LOCK:
        begin
          if (cnt_q == 32'h0)
            state_q <= srs_pkg::ST_RUN;
          else
            cnt_q <= cnt_q - 32'h1;
        end
        srs_pkg::ST_RUN:
        begin
          if (master_clear_pin_act)
            state_q <= srs_pkg::ST_MASTER_CLEAR_PIN;
          else if (wdt_rst_evt || sw_evt)
            state_q <= srs_pkg::ST_PULSE;
        end
        srs_pkg::ST_MASTER_CLEAR_PIN:
        begin
          if (!master_clear_pin_act)
            state_q <= srs_pkg::ST_RUN;
        end
        srs_pkg::ST_PULSE:
          state_q <= master_clear_pin_act ? srs_pkg::ST_MASTER_CLEAR_PIN : srs_pkg::ST_RUN;
        default:
          state_q <= srs_pkg::ST_POR;
      endcase
    end
  end

  // ****************************************
  // clock source and outputs
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      clk_sel_q <= 3'h0;
    else if (state_q == srs_pkg::ST_POR || state_q == srs_pkg::ST_BOR)
      clk_sel_q <= initial_osc_select;
  end
  // warm states leave clk_sel_q untouched

  logic in_reset;
  logic clk_rdy;
  assign in_reset = (state_q == srs_pkg::ST_POR) || (state_q == srs_pkg::ST_BOR)
    || (state_q == srs_pkg::ST_POWER_UP_TIMER) || (state_q == srs_pkg::ST_MASTER_CLEAR_PIN)
    || (state_q == srs_pkg::ST_PULSE);
  assign clk_rdy = (state_q == srs_pkg::ST_RUN) || (state_q == srs_pkg::ST_MASTER_CLEAR_PIN)
    || (state_q == srs_pkg::ST_PULSE);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      system_reset_n <= 1'b0;
      osc_enable <= 1'b0;
      clock_ready <= 1'b0;
      cpu_fetch_en <= 1'b0;
      reset_vector <= 24'h000000;
      wdt_wake <= 1'b0;
    end
    else
    begin
      system_reset_n <= !in_reset;
      osc_enable <= !in_reset || clk_rdy;
      clock_ready <= clk_rdy;
      cpu_fetch_en <= (state_q == srs_pkg::ST_RUN);
      reset_vector <= 24'h000000;
      wdt_wake <= wdt_timeout && cpu_sleep_or_idle && (state_q == srs_pkg::ST_RUN);
    end
  end

  assign clk_source_sel = clk_sel_q;

  // ****************************************
  // fail-safe clock monitor start
  // ****************************************
  logic [15:0] fail_safe_clock_monitor_cnt_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !clk_rdy)
      fail_safe_clock_monitor_cnt_q <= 16'(srs_pkg::CLOCK_MONITOR_START_CYC);
    else if (fail_safe_clock_monitor_cnt_q != 16'h0)
      fail_safe_clock_monitor_cnt_q <= fail_safe_clock_monitor_cnt_q - 16'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      clock_monitor_active <= 1'b0;
    else
      clock_monitor_active <= cfg_q[srs_pkg::CFG_FAIL_SAFE_CLOCK_MONITOR_EN_BIT] && clk_rdy
        && (fail_safe_clock_monitor_cnt_q == 16'h0);
  end

  // ****************************************
  // reset status flags
  // ****************************************
  logic [15:0] reset_control_reg_q;
  logic [15:0] reset_control_reg_d;

  always_comb
  begin
    reset_control_reg_d = reset_control_reg_q;
    if (we_reset_control_reg)
      reset_control_reg_d = hwdata[15:0] & srs_pkg::RESET_CONTROL_REG_MASK;
    // hardware set wins over a software clear in the same cycle
    if (master_clear_pin_act)
      reset_control_reg_d[srs_pkg::EXTERNAL_RESET_FLAG_BIT] = 1'b1;
    if (sw_evt)
      reset_control_reg_d[srs_pkg::SWR_BIT] = 1'b1;
    if (wdt_rst_evt)
      reset_control_reg_d[srs_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
    if (!bor_ok)
    begin
      reset_control_reg_d[srs_pkg::BOR_BIT] = 1'b1;
      reset_control_reg_d[srs_pkg::SWR_BIT] = 1'b0;
      reset_control_reg_d[srs_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
    end
    if (!por_ok)
      reset_control_reg_d = srs_pkg::RESET_CONTROL_REG_RESET;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reset_control_reg_q <= srs_pkg::RESET_CONTROL_REG_RESET;
    else
      reset_control_reg_q <= reset_control_reg_d;
  end

  // ****************************************
  // ahb-lite slave, one wait state
  // ****************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    case (addr_q)
      srs_pkg::RESET_CONTROL_REG_OFS: rd_mux = {16'h0, reset_control_reg_q};
      srs_pkg::OSC_CONTROL_REG_OFS: rd_mux = {17'h0, clk_sel_q, 12'h0};
      srs_pkg::SEQ_CONFIG_REG_OFS: rd_mux = {28'h0, cfg_q};
      srs_pkg::SEQ_STATUS_REG_OFS:
        rd_mux = {25'h0, system_reset_n, clock_monitor_active, clock_ready, state_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end
    else if (pend_q)
    begin
      pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= wr_q ? 32'h0 : rd_mux;
    end
    else if (hsel && htrans[1] && hready)
    begin
      pend_q <= 1'b1;
      wr_q <= hwrite;
      addr_q <= (haddr[31:8] == 24'h0) ? {haddr[7:2], 2'b00} : 8'hff;
      hreadyout <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  chk_cold_clk_select: assert property ((state_q == srs_pkg::ST_POR) |=>
    clk_sel_q == $past(initial_osc_select)) else $error("cold clock select wrong");
  chk_warm_keeps_clk: assert property ((state_q == srs_pkg::ST_PULSE) |=>
    $stable(clk_sel_q)) else $error("warm reset changed clock");
  chk_por_holds_reset: assert property (!por_ok |-> ##2 !system_reset_n)
    else $error("reset released under power-on");
  chk_por_flags: assert property (!por_ok |=> reset_control_reg_q == srs_pkg::RESET_CONTROL_REG_RESET)
    else $error("power-on flags wrong");
  chk_bor_flag: assert property (por_ok && !bor_ok |=> reset_control_reg_q[srs_pkg::BOR_BIT])
    else $error("brown-out flag not set");
  chk_power_up_timer_holds: assert property ((state_q == srs_pkg::ST_POWER_UP_TIMER) |=> !system_reset_n)
    else $error("reset released during power-up timer");
  chk_swr_one_cycle: assert property ((state_q == srs_pkg::ST_PULSE) && por_ok && bor_ok
    && !master_clear_pin_act |=> state_q == srs_pkg::ST_RUN ##1 system_reset_n)
    else $error("software reset not released");
  chk_swr_flag: assert property (sw_evt && por_ok && bor_ok |=> reset_control_reg_q[srs_pkg::SWR_BIT])
    else $error("software reset flag not set");
  chk_wdt_sleep_wake: assert property (wdt_timeout && cpu_sleep_or_idle
    && (state_q == srs_pkg::ST_RUN) |=> wdt_wake) else $error("watchdog did not wake");
  chk_master_clear_pin_glitch: assert property (master_clear_pin_n |=> !master_clear_pin_act)
    else $error("master clear glitch honoured");

  cov_reach_run: cover property ($rose(cpu_fetch_en));
  cov_sw_reset: cover property (sw_evt ##2 state_q == srs_pkg::ST_RUN);
  cov_master_clear_pin_reset: cover property (state_q == srs_pkg::ST_MASTER_CLEAR_PIN);
  cov_pll_lock: cover property (state_q == srs_pkg::ST_LOCK);

endmodule

`default_nettype wire

// >>> tb/srs_supervisor.sv
// external supervisory circuit model driving the master clear pin
`timescale 1ns/1ps
`default_nettype none

module srs_supervisor (
  // clock
  input wire logic ref_clk,
  // reset pin
  output logic master_clear_pin_n
);
  // pin is tied high through a resistor when the supervisor lets go
  initial master_clear_pin_n = 1'b1;

  // ****************************************
  // reset pulse
  // ****************************************
  task automatic press(input int n);
    @(posedge ref_clk);
    master_clear_pin_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    master_clear_pin_n <= 1'b1;
  endtask
endmodule

`default_nettype wire

// >>> tb/system_reset_sequencer_test.sv
// self-checking bench for the system reset sequencer
`timescale 1ns/1ps
`default_nettype none

module system_reset_sequencer_test;
  // small counts keep the run short; expectations use the same values
  localparam int LOW_POWER_INTERNAL_RC = 4;
  localparam int PLL = 8;
  localparam int STEP = 4;
  logic ref_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize, initial_osc_select, clk_source_sel, sel;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic supply_above_por, supply_above_bor, master_clear_pin_n, sw_reset_req, wdt_timeout;
  logic cpu_sleep_or_idle, osc_tick, system_reset_n, osc_enable, clock_ready, cpu_fetch_en;
  logic clock_monitor_active, wdt_wake;
  logic [23:0] reset_vector;
  int n_errors, checks, c, lo, wk;

  assign hready = hreadyout;

  srs_reset_seq #(.OSCD_LOW_POWER_INTERNAL_RC_CYC(LOW_POWER_INTERNAL_RC), .PLL_LOCK_CYC(PLL), .POWER_UP_TIMER_STEP_CYC(STEP)) srs_reset_seq_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .supply_above_por(supply_above_por),
    .supply_above_bor(supply_above_bor), .master_clear_pin_n(master_clear_pin_n),
    .sw_reset_req(sw_reset_req), .wdt_timeout(wdt_timeout), .cpu_sleep_or_idle(cpu_sleep_or_idle),
    .initial_osc_select(initial_osc_select), .osc_tick(osc_tick), .system_reset_n(system_reset_n),
    .clk_source_sel(clk_source_sel), .osc_enable(osc_enable), .clock_ready(clock_ready),
    .cpu_fetch_en(cpu_fetch_en), .reset_vector(reset_vector),
    .clock_monitor_active(clock_monitor_active), .wdt_wake(wdt_wake));

  srs_supervisor srs_supervisor_i (.ref_clk(ref_clk), .master_clear_pin_n(master_clear_pin_n));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // oscillator ticks every other cycle so start-up counts are visible
  always @(posedge ref_clk) osc_tick <= ~osc_tick;

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo_b, input int hi_b);
    checks++;
    if (v < lo_b || v > hi_b)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, v, lo_b);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    r = hrdata;
    chk(hresp, 1'b0);
  endtask

  function automatic int power_up_timer(input logic [2:0] s);
    return (s == 3'h0) ? 0 : (STEP << s);
  endfunction

  function automatic int ready_cyc(input logic [2:0] m);
    int d;
    d = 0;
    if (m != srs_pkg::OSC_EC && m != srs_pkg::OSC_ECPLL)
      d = (m == srs_pkg::OSC_LOW_POWER_INTERNAL_RC) ? LOW_POWER_INTERNAL_RC : srs_pkg::OSCD_FRC_CYC;
    if (m == srs_pkg::OSC_XT || m == srs_pkg::OSC_XTPLL)
      d += 2 * srs_pkg::OST_PERIODS;
    if (m == srs_pkg::OSC_FRCPLL || m == srs_pkg::OSC_XTPLL || m == srs_pkg::OSC_ECPLL)
      d += PLL;
    return d;
  endfunction

  task automatic wait_rel();
    c = 0;
    while (system_reset_n !== 1'b1 && c < 6000)
    begin
      @(negedge ref_clk);
      c++;
    end
  endtask

  task automatic wait_fetch();
    c = 0;
    while (cpu_fetch_en !== 1'b1 && c < 6000)
    begin
      @(negedge ref_clk);
      c++;
    end
  endtask

  task automatic warm(input bit wdt);
    @(posedge ref_clk);
    if (wdt)
      wdt_timeout <= 1'b1;
    else
      sw_reset_req <= 1'b1;
    @(posedge ref_clk);
    wdt_timeout <= 1'b0;
    sw_reset_req <= 1'b0;
    lo = 0;
    wk = 0;
    repeat (8)
    begin
      @(negedge ref_clk);
      if (system_reset_n !== 1'b1) lo++;
      if (wdt_wake === 1'b1) wk++;
    end
    wait_fetch();
  endtask

  task automatic master_clear_pin(input int n);
    lo = 0;
    fork
      srs_supervisor_i.press(n);
      repeat (n + 20)
      begin
        @(negedge ref_clk);
        if (system_reset_n !== 1'b1) lo++;
      end
    join
    wait_fetch();
  endtask

  task automatic done(input string s);
    $display("test %s finished, errors %0d", s, n_errors);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // the sequence needs under 30k cycles; 100k cycles means a hang
  initial
  begin
    #1000000;
    n_errors++;
    end_sim();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    {hsel, hwrite, sw_reset_req, wdt_timeout, cpu_sleep_or_idle, osc_tick} = '0;
    {supply_above_por, supply_above_bor, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    initial_osc_select = 3'h0;
    n_errors = 0;
    checks = 0;
    void'($urandom(32'hc5de6af0));
    sys_rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h3);
    ahb(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'he);
    ahb(1'b1, 8'h14, 32'hffff, rd);
    ahb(1'b0, 8'h14, 32'h0, rd);
    chk(rd, 32'h0);
    chk(system_reset_n, 1'b0);
    @(posedge ref_clk);
    supply_above_por <= 1'b1;
    supply_above_bor <= 1'b1;
    wait_rel();
    rng(c, 2000 + power_up_timer(3'h7), 2008 + power_up_timer(3'h7));
    chk(osc_enable, 1'b1);
    wait_fetch();
    chk(clock_ready, 1'b1);
    chk(reset_vector, 24'h0);
    chk(clk_source_sel, 3'h0);
    done("power_on");
    for (int m = 0; m < 8; m++)
    begin
      sel = (m == 7) ? 3'h7 : (m == 0) ? 3'h0 : 3'($urandom_range(7, 0));
      ahb(1'b1, 8'h08, {28'h0, sel, 1'b1}, rd);
      initial_osc_select <= m[2:0];
      supply_above_bor <= 1'b0;
      // two sync flops, the state edge, then the output flop: look one edge later
      repeat (5) @(posedge ref_clk);
      chk(system_reset_n, 1'b0);
      supply_above_bor <= 1'b1;
      repeat (300) @(posedge ref_clk);
      supply_above_bor <= 1'b0;
      repeat (4) @(posedge ref_clk);
      supply_above_bor <= 1'b1;
      wait_rel();
      rng(c, 1000 + power_up_timer(sel), 1008 + power_up_timer(sel));
      wait_fetch();
      rng(c, ready_cyc(m[2:0]), ready_cyc(m[2:0]) + 8);
      chk(clock_monitor_active, 1'b0);
      c = 0;
      while (clock_monitor_active !== 1'b1 && c < 1000)
      begin
        @(negedge ref_clk);
        c++;
      end
      rng(c, 495, 505);
      chk(clk_source_sel, m[2:0]);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk(rd[14:12], m[2:0]);
      ahb(1'b0, 8'h00, 32'h0, rd);
      chk(rd[1], 1'b1);
      done("brown_out_mode");
    end
    warm(1'b0);
    chk(lo, 1);
    chk(clk_source_sel, 3'h7);
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk(rd[6], 1'b1);
    warm(1'b1);
    chk(lo, 1);
    chk(clk_source_sel, 3'h7);
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk(rd[4], 1'b1);
    @(posedge ref_clk);
    cpu_sleep_or_idle <= 1'b1;
    warm(1'b1);
    chk(lo, 0);
    chk(wk, 1);
    cpu_sleep_or_idle <= 1'b0;
    done("warm");
    master_clear_pin(50);
    chk(lo, 0);
    master_clear_pin(300);
    rng(lo, 94, 106);
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk(rd[7], 1'b1);
    done("master_clear");
    ahb(1'b1, 8'h00, 32'hd3, rd);
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'hd3);
    chk(system_reset_n, 1'b1);
    ahb(1'b1, 8'h00, 32'h0, rd);
    ahb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h0);
    done("flag_write");
    end_sim();
  end
endmodule

`default_nettype wire
